/* design/ecfd_pkg.sv */
// Constants, register map and helpers of the external clock failure detector
// Function
// [R1] Detector state cleared only by power-on reset
// [R2] Oscillator disabled: no monitoring, no failure report
// [R3] Software starts fast oscillator before enabling detection
// [R4] Writing failure-detect enable starts detector operation
// [R5] Suppress reporting until start-up time elapses
// [R6] Need rise and fall within four safe periods
// [R7] Failure sets status bit and interrupt flag
// [R8] Failure with enable raises interrupt request
// [R9] Failure with event enable emits output event
// [R10] Monitoring continues; status follows present activity
// [R11] Failure substitutes safe clock for external clock
// [R12] Safe clock from fast oscillator via prescaler
// [R13] Substitution sets the clock-switched status bit
// [R14] Oscillator stays enabled; software reconfigures clocks
// [R15] Software may switch back after recovery
// [R16] Sleep without oscillator request disables detector
// [R17] Sync external edges; window restarts every four
package ecfd_pkg;

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] ECFD_OFS_CTRL     = 8'h00;
  localparam logic [7:0] ECFD_OFS_STARTUP  = 8'h04;
  localparam logic [7:0] ECFD_OFS_PRESC    = 8'h08;
  localparam logic [7:0] ECFD_OFS_INTEN    = 8'h0C;
  localparam logic [7:0] ECFD_OFS_EVCTRL   = 8'h10;
  localparam logic [7:0] ECFD_OFS_INTERRUPT_FLAG_REGISTER  = 8'h14;
  localparam logic [7:0] ECFD_OFS_STATUS   = 8'h18;
  localparam logic [7:0] ECFD_OFS_SWITCH   = 8'h1C;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int ECFD_CTRL_OSC_EN_BIT   = 0;
  localparam int ECFD_CTRL_FD_EN_BIT    = 1;
  localparam int ECFD_INT_FAIL_BIT      = 0;
  localparam int ECFD_EV_FAIL_BIT       = 0;
  localparam int ECFD_SW_BACK_BIT       = 0;
  localparam int ECFD_ST_FAIL_BIT       = 0;
  localparam int ECFD_ST_SWITCHED_BIT   = 1;
  localparam int ECFD_ST_MONITOR_BIT    = 2;
  localparam int ECFD_ST_STARTUP_BIT    = 3;

  // ***************************************************************
  // Reset values and timing counts
  // ***************************************************************
  localparam logic [1:0]  ECFD_CTRL_RST     = 2'h0;
  localparam logic [15:0] ECFD_STARTUP_RST  = 16'h0010;
  localparam logic [7:0]  ECFD_PRESC_RST    = 8'h03;
  localparam logic [1:0]  ECFD_WIN_LAST     = 2'h3;
  localparam logic [31:0] ECFD_UNMAPPED_RD  = 32'h00000000;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] ecfd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

/* design/ecfd_sync.sv */
// Two-stage synchroniser with asynchronous reset to a constant
`timescale 1ns/10ps
module ecfd_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);

  logic stage1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

/* design/ecfd_top.sv */
// External clock failure detector with Avalon-MM register slave
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module ecfd_top
  import ecfd_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // External oscillator side
  input  wire logic              ext_osc_clk,
  output logic                   ext_osc_enable,
  // System side
  input  wire logic              sleep_mode,
  input  wire logic              osc_run_request,
  output logic                   safe_clk,
  output logic                   clk_sel_safe,
  output logic                   irq,
  output logic                   fail_event
);

  // ***************************************************************
  // Reset release and external clock synchronisation
  // ***************************************************************
  logic rst_n;
  logic ext_sync;
  logic ext_prev;

  // Power-on reset is the only reset of this block
  ecfd_sync #(.RESET_VAL(1'b0)) u_rst_sync ( // [R1]
    .clock  (clock),
    .arst_n (arst_n),
    .din    (1'b1),
    .dout   (rst_n)
  );

  ecfd_sync #(.RESET_VAL(1'b0)) u_ext_sync ( // [R17]
    .clock  (clock),
    .arst_n (arst_n),
    .din    (ext_osc_clk),
    .dout   (ext_sync)
  );

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [1:0]  ctrl;
  logic [15:0] startup_val;
  logic [7:0]  presc_div;
  logic        inten;
  logic        evctrl;
  logic        interrupt_flag_register;
  logic        fail_status;

  logic [7:0]  presc_cnt;
  logic [15:0] startup_cnt;
  logic [1:0]  win_cnt;
  logic        seen_rise;
  logic        seen_fall;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  wire         bus_req      = avs_read | avs_write;
  wire         wr_done      = avs_write & ~avs_waitrequest;
  wire [7:0]   ofs          = 8'(avs_address);
  wire         sel_ctrl     = (ofs == ECFD_OFS_CTRL);
  wire         sel_startup  = (ofs == ECFD_OFS_STARTUP);
  wire         sel_presc    = (ofs == ECFD_OFS_PRESC);
  wire         sel_inten    = (ofs == ECFD_OFS_INTEN);
  wire         sel_evctrl   = (ofs == ECFD_OFS_EVCTRL);
  wire         sel_interrupt_flag_register  = (ofs == ECFD_OFS_INTERRUPT_FLAG_REGISTER);
  wire         sel_status   = (ofs == ECFD_OFS_STATUS);
  wire         sel_switch   = (ofs == ECFD_OFS_SWITCH);

  wire [31:0]  wr_ctrl      = ecfd_merge({30'h0, ctrl}, avs_writedata, avs_byteenable);
  wire [31:0]  wr_startup   = ecfd_merge({16'h0, startup_val}, avs_writedata,
                                         avs_byteenable);
  wire [31:0]  wr_presc     = ecfd_merge({24'h0, presc_div}, avs_writedata,
                                         avs_byteenable);
  wire         lane0_wr     = wr_done & avs_byteenable[0];

  wire         clr_interrupt_flag_register  = lane0_wr & sel_interrupt_flag_register & avs_writedata[ECFD_INT_FAIL_BIT];
  wire         switch_back  = lane0_wr & sel_switch & avs_writedata[ECFD_SW_BACK_BIT];

  // ***************************************************************
  // Safe clock prescaler
  // ***************************************************************
  wire         safe_tick      = (presc_cnt >= presc_div); // [R12]
  wire [7:0]   next_presc_cnt = safe_tick ? 8'h00 : 8'(presc_cnt + 8'h01);
  wire         next_safe_clk  = (next_presc_cnt <= {1'b0, presc_div[7:1]});

  // ***************************************************************
  // Start-up wait and monitor qualification
  // ***************************************************************
  wire         osc_en        = ctrl[ECFD_CTRL_OSC_EN_BIT];
  wire         fd_en         = ctrl[ECFD_CTRL_FD_EN_BIT];
  wire         startup_busy  = (startup_cnt != 16'h0000);
  wire         sleep_block   = sleep_mode & ~osc_run_request; // [R16]
  wire         monitor_on    = osc_en & fd_en & ~sleep_block & ~startup_busy; // [R2] [R4] [R5]

  wire [15:0]  next_startup_cnt = !osc_en ? startup_val :
                                  (safe_tick && startup_busy) ?
                                  16'(startup_cnt - 16'h0001) : startup_cnt; // [R5]

  // ***************************************************************
  // Edge watch over the monitor window
  // ***************************************************************
  wire         ext_rise      = ext_sync & ~ext_prev; // [R17]
  wire         ext_fall      = ~ext_sync & ext_prev;
  wire         any_rise      = seen_rise | ext_rise;
  wire         any_fall      = seen_fall | ext_fall;
  wire         win_end       = monitor_on & safe_tick & (win_cnt == ECFD_WIN_LAST);
  wire         fail_now      = win_end & ~(any_rise & any_fall); // [R6]

  wire [1:0]   next_win_cnt  = !monitor_on ? 2'h0 :
                               safe_tick ? 2'(win_cnt + 2'h1) : win_cnt; // [R17]
  wire         next_seen_rise = monitor_on & ~win_end & any_rise;
  wire         next_seen_fall = monitor_on & ~win_end & any_fall;

  // Status follows each window's verdict while monitoring
  wire         next_fail_status = !monitor_on ? 1'b0 :
                                  win_end ? fail_now : fail_status; // [R10]

  // Hardware set wins over software clear
  wire         next_interrupt_flag_register  = fail_now | (interrupt_flag_register & ~clr_interrupt_flag_register); // [R7]
  wire         back_ok       = switch_back & ~fail_status & ~fail_now; // [R15]
  wire         next_sel_safe = fail_now | (clk_sel_safe & ~back_ok); // [R11] [R13]

  // ***************************************************************
  // Next register values
  // ***************************************************************
  wire [1:0]   next_ctrl     = (wr_done && sel_ctrl) ? wr_ctrl[1:0] : ctrl; // [R4] [R14]
  wire [15:0]  next_startup  = (wr_done && sel_startup) ? wr_startup[15:0] : startup_val;
  wire [7:0]   next_presc    = (wr_done && sel_presc) ? wr_presc[7:0] : presc_div;
  wire         next_inten    = (lane0_wr && sel_inten) ?
                               avs_writedata[ECFD_INT_FAIL_BIT] : inten;
  wire         next_evctrl   = (lane0_wr && sel_evctrl) ?
                               avs_writedata[ECFD_EV_FAIL_BIT] : evctrl;

  // ***************************************************************
  // Read mux
  // ***************************************************************
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = 32'h00000000;
    status_word[ECFD_ST_FAIL_BIT]     = fail_status;
    status_word[ECFD_ST_SWITCHED_BIT] = clk_sel_safe;
    status_word[ECFD_ST_MONITOR_BIT]  = monitor_on;
    status_word[ECFD_ST_STARTUP_BIT]  = startup_busy;
  end

  assign rd_mux = sel_ctrl    ? {30'h0, ctrl} :
                  sel_startup ? {16'h0, startup_val} :
                  sel_presc   ? {24'h0, presc_div} :
                  sel_inten   ? {31'h0, inten} :
                  sel_evctrl  ? {31'h0, evctrl} :
                  sel_interrupt_flag_register ? {31'h0, interrupt_flag_register} :
                  sel_status  ? status_word :
                  ECFD_UNMAPPED_RD;

  // ***************************************************************
  // Bus handshake: one wait cycle per access
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin // [R1]
      ctrl        <= ECFD_CTRL_RST;
      startup_val <= ECFD_STARTUP_RST;
      presc_div   <= ECFD_PRESC_RST;
      inten       <= 1'b0;
      evctrl      <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      startup_val <= next_startup;
      presc_div   <= next_presc;
      inten       <= next_inten;
      evctrl      <= next_evctrl;
    end
  end

  // ***************************************************************
  // Prescaler, start-up and window state
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt   <= 8'h00;
      safe_clk    <= 1'b0;
      startup_cnt <= ECFD_STARTUP_RST;
      win_cnt     <= 2'h0;
      seen_rise   <= 1'b0;
      seen_fall   <= 1'b0;
      ext_prev    <= 1'b0;
    end else begin
      presc_cnt   <= next_presc_cnt;
      safe_clk    <= next_safe_clk; // [R12]
      startup_cnt <= next_startup_cnt;
      win_cnt     <= next_win_cnt;
      seen_rise   <= next_seen_rise;
      seen_fall   <= next_seen_fall;
      ext_prev    <= ext_sync;
    end
  end

  // ***************************************************************
  // Failure reporting and clock switch
  // ***************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fail_status    <= 1'b0;
      interrupt_flag_register        <= 1'b0;
      clk_sel_safe   <= 1'b0;
      irq            <= 1'b0;
      fail_event     <= 1'b0;
      ext_osc_enable <= 1'b0;
    end else begin
      fail_status    <= next_fail_status; // [R10]
      interrupt_flag_register        <= next_interrupt_flag_register; // [R7]
      clk_sel_safe   <= next_sel_safe; // [R11] [R13]
      irq            <= next_interrupt_flag_register & next_inten; // [R8]
      fail_event     <= fail_now & evctrl; // [R9]
      ext_osc_enable <= next_ctrl[ECFD_CTRL_OSC_EN_BIT]; // [R14]
    end
  end

endmodule

/* dv/ecfd_osc_model.sv */
// External oscillator model driving the monitored clock
`timescale 1ns/10ps
module ecfd_osc_model #(
  parameter realtime HALF = 80.0
) (
  input  wire logic enable,
  input  wire logic run,
  output logic      clk_out
);
  initial clk_out = 1'b0;
  // Toggles only while enabled and not stalled
  always begin
    #HALF;
    if (enable && run) begin
      clk_out = ~clk_out;
    end
  end
endmodule

/* dv/ecfd_properties.sv */
// Port checker of the external clock failure detector
`timescale 1ns/10ps
module ecfd_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              ext_osc_clk,
  input wire logic              ext_osc_enable,
  input wire logic              sleep_mode,
  input wire logic              osc_run_request,
  input wire logic              safe_clk,
  input wire logic              clk_sel_safe,
  input wire logic              irq,
  input wire logic              fail_event
);
  wire logic wr_done = avs_write && !avs_waitrequest;
  wire logic ctrl_wr = wr_done && (avs_address == 8'h00);
  wire logic sw_wr   = wr_done && (avs_address == 8'h1C) && avs_writedata[0];
  logic      ev_on;
  // Mirror of the event enable, seen from the bus
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ev_on <= 1'b0;
    end else if (wr_done && (avs_address == 8'h10) && avs_byteenable[0]) begin
      ev_on <= avs_writedata[0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("wait cycle wrong");
  unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 8'h1C
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  off_quiet_a: assert property (!ext_osc_enable && !$past(ext_osc_enable)
    |-> !fail_event) else $error("failure while oscillator off");
  event_pulse_a: assert property (fail_event |=> !fail_event)
    else $error("event longer than one cycle");
  fail_switch_a: assert property (fail_event |-> clk_sel_safe)
    else $error("no substitution on failure");
  switch_cause_a: assert property ($rose(clk_sel_safe)
    |-> fail_event || !$past(ev_on)) else $error("substitution without failure");
  osc_kept_a: assert property ($fell(ext_osc_enable)
    |-> $past(ctrl_wr, 1)) else $error("oscillator dropped");
  switch_back_a: assert property ($fell(clk_sel_safe)
    |-> $past(sw_wr, 1) || $past(sw_wr, 2)) else $error("switch back uncommanded");
  sleep_idle_a: assert property ((sleep_mode && !osc_run_request) [*2]
    |-> !fail_event) else $error("failure reported in sleep");
endmodule

bind ecfd_top ecfd_properties #(.ADDR_W(ADDR_W)) u_props (
  .clock(clock), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ext_osc_clk(ext_osc_clk),
  .ext_osc_enable(ext_osc_enable), .sleep_mode(sleep_mode),
  .osc_run_request(osc_run_request), .safe_clk(safe_clk),
  .clk_sel_safe(clk_sel_safe), .irq(irq), .fail_event(fail_event));

/* dv/tb.sv */
// Self-checking bench of the external clock failure detector
`timescale 1ns/10ps
module tb
  import ecfd_pkg::*;
;
  logic        clock, arst_n, avs_read, avs_write, avs_waitrequest;
  logic        ext_osc_clk, ext_osc_enable, sleep_mode, osc_run_request;
  logic        safe_clk, clk_sel_safe, irq, fail_event, osc_run, last_sc;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  int          n_errors, n_tests, n_ev, cyc, rises;

  ecfd_top DUT (.clock(clock), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_osc_clk(ext_osc_clk),
    .ext_osc_enable(ext_osc_enable), .sleep_mode(sleep_mode),
    .osc_run_request(osc_run_request), .safe_clk(safe_clk),
    .clk_sel_safe(clk_sel_safe), .irq(irq), .fail_event(fail_event));
  ecfd_osc_model u_osc (.enable(ext_osc_enable), .run(osc_run), .clk_out(ext_osc_clk));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  always @(negedge clock) begin
    if (fail_event === 1'b1) begin
      n_ev++;
    end
  end

  // ***************************************************************
  // Bus access and comparison
  // ***************************************************************
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    sleep_mode = 1'b0;
    osc_run_request = 1'b1;
    osc_run = 1'b0;
    n_errors = 0;
    n_tests = 0;
    n_ev = 0;
    cyc = 0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rchk("ctrl", ECFD_OFS_CTRL, 32'h0);
    rchk("startup", ECFD_OFS_STARTUP, 32'h10);
    rchk("presc", ECFD_OFS_PRESC, 32'h3);
    acc(1'b1, ECFD_OFS_STATUS, 32'hF);
    rchk("status ro", ECFD_OFS_STATUS, 32'h8);
    acc(1'b1, 8'h40, 32'hFFFFFFFF);
    rchk("unmapped", 8'h40, 32'h0);
    for (int p = 1; p < 4; p += 2) begin
      acc(1'b1, ECFD_OFS_PRESC, 32'(p));
      // Let the prescaler settle into its new period
      repeat (4) @(negedge clock);
      last_sc = safe_clk;
      rises = 0;
      repeat (40) begin
        @(negedge clock);
        if (safe_clk === 1'b1 && last_sc === 1'b0) rises++;
        last_sc = safe_clk;
      end
      chk("safe ticks", 32'(40 / (p + 1)), 32'(rises));
    end
    acc(1'b1, ECFD_OFS_CTRL, 32'h2);
    repeat (120) @(negedge clock);
    chk("event off", 32'h0, 32'(n_ev));
    acc(1'b1, ECFD_OFS_STARTUP, 32'h4);
    acc(1'b1, ECFD_OFS_INTEN, 32'h1);
    acc(1'b1, ECFD_OFS_EVCTRL, 32'h1);
    acc(1'b1, ECFD_OFS_CTRL, 32'h3);
    rchk("status start", ECFD_OFS_STATUS, 32'h8);
    chk("osc enable", 32'h1, 32'(ext_osc_enable));
    osc_run <= 1'b1;
    repeat (60) @(negedge clock);
    chk("event start", 32'h0, 32'(n_ev));
    rchk("status run", ECFD_OFS_STATUS, 32'h4);
    osc_run <= 1'b0;
    repeat (48) @(negedge clock);
    chk("event fail", 32'h1, 32'(n_ev != 0));
    chk("irq", 32'h1, 32'(irq));
    chk("sel safe", 32'h1, 32'(clk_sel_safe));
    rchk("status fail", ECFD_OFS_STATUS, 32'h7);
    rchk("interrupt_flag_register", ECFD_OFS_INTERRUPT_FLAG_REGISTER, 32'h1);
    acc(1'b1, ECFD_OFS_SWITCH, 32'h1);
    repeat (2) @(negedge clock);
    chk("sel kept", 32'h1, 32'(clk_sel_safe));
    chk("osc kept", 32'h1, 32'(ext_osc_enable));
    @(posedge clock);
    osc_run <= 1'b1;
    repeat (48) @(negedge clock);
    rchk("status back", ECFD_OFS_STATUS, 32'h6);
    acc(1'b1, ECFD_OFS_INTERRUPT_FLAG_REGISTER, 32'h1);
    rchk("flag clear", ECFD_OFS_INTERRUPT_FLAG_REGISTER, 32'h0);
    chk("irq clear", 32'h0, 32'(irq));
    acc(1'b1, ECFD_OFS_SWITCH, 32'h1);
    repeat (2) @(negedge clock);
    chk("sel back", 32'h0, 32'(clk_sel_safe));
    @(posedge clock);
    sleep_mode <= 1'b1;
    osc_run_request <= 1'b0;
    osc_run <= 1'b0;
    n_ev = 0;
    repeat (60) @(negedge clock);
    chk("event sleep", 32'h0, 32'(n_ev));
    @(posedge clock);
    osc_run_request <= 1'b1;
    repeat (60) @(negedge clock);
    chk("event wake", 32'h1, 32'(n_ev != 0));
    // Software may drop the oscillator itself
    acc(1'b1, ECFD_OFS_CTRL, 32'h0);
    @(negedge clock);
    chk("osc off", 32'h0, 32'(ext_osc_enable));
    finish_test();
  end
endmodule
